//--- hw/fogp_fail_out.v
// Fail outputs with alternate GPIO use of pins two and three
//
// Functional notes
// - All three fail outputs activate together when failure signalling starts.
// - Static fail output held low while signalling is active.
// - Blink output toggles at 1.25 Hz, 50 percent duty.
// - Dimmed output is 100 Hz PWM, 20 percent after reset.
// - Duty selectable among 20, 10, 5, 2.5 percent; default 20.
// - Tolerant configuration ignores the first watchdog failure.
// - Pins two and three default to fail outputs; software may reassign.
// - Wake-configured pin detects wakes, latched in second wake status.
// - Low-side switch pulls pin low when on; current limit only.
// - High-side switch drives pin high from high-side supply; limit only.
// - Normal and Stop modes show live GPIO pin levels.
// - Pin two level shares the test level status bit.
// - Configuration changes only in Normal; otherwise held or off.
// - Wake pin stays capable in Stop, Sleep, Restart; off in Fail-Safe.
// - Switches disabled in Restart and Fail-Safe, resume afterwards.
// - Failure-activated outputs stay active through Restart into Normal.
// - Test pin level filtered for 64 microseconds.
// - Failure flag set on activation; software clears when cause gone.
// - Force-on bit activates outputs independently of failure bits.
`timescale 1ns/10ps
`include "fogp_defines.vh"
module fogp_fail_out
#(
  parameter BLINK_HALF = `FOGP_BLINK_HALF,
  parameter PWM_PERIOD = `FOGP_PWM_PERIOD,
  parameter TEST_FLT   = `FOGP_TEST_FLT_CYC
)
(
  // Clock and reset
  input  wire       mclk,
  input  wire       rst,
  // System state
  input  wire [4:0] sys_mode,
  input  wire       fail_cond,
  input  wire       wd_fail_event,
  input  wire       wd_tolerant_cfg,
  // Software control
  input  wire       fail_force_on,
  input  wire       failure_clear,
  input  wire [1:0] fail_pwm_duty_sel,
  input  wire [2:0] cfg_two_wr,
  input  wire [2:0] cfg_three_wr,
  input  wire       cfg_wr,
  input  wire       wake_clear,
  // Pin inputs (asynchronous)
  input  wire       alt_pin_two_in,
  input  wire       test_pin_in,
  // Static fail pin, open drain
  output reg        static_fail_out,
  output reg        static_fail_oe,
  // Pin two drive
  output reg        blink_fail_out,
  output reg        blink_fail_oe,
  output reg        blink_hs_on,
  // Pin three drive
  output reg        dimmed_fail_out,
  output reg        dimmed_fail_oe,
  output reg        dimmed_hs_on,
  // Status
  output reg        device_status_reg,
  output wire [1:0] wake_status_two,
  output reg  [1:0] pin_level_status,
  output wire       test_level,
  output wire [2:0] cfg_two_rd,
  output wire [2:0] cfg_three_rd
);
  // ------------------------------------------------
  // Mode decode
  // ------------------------------------------------
  wire m_normal  = (sys_mode == `FOGP_MODE_NORMAL);
  wire m_stop    = (sys_mode == `FOGP_MODE_STOP);
  wire m_restart = (sys_mode == `FOGP_MODE_RESTART);
  wire m_fsafe   = (sys_mode == `FOGP_MODE_FAILSAFE);

  // ------------------------------------------------
  // Pin configuration registers
  // ------------------------------------------------
  reg  [2:0] cfg_two_ff;
  reg  [2:0] cfg_three_ff;
  assign cfg_two_rd   = cfg_two_ff;
  assign cfg_three_rd = cfg_three_ff;

  // Writes accepted only in Normal mode; held elsewhere
  always @(posedge mclk)
  begin
    if (rst)
    begin
      cfg_two_ff   <= `FOGP_CFG_FO;
      cfg_three_ff <= `FOGP_CFG_FO;
    end
    else if (cfg_wr && m_normal)
    begin
      cfg_two_ff   <= cfg_two_wr;
      cfg_three_ff <= cfg_three_wr;
    end
  end

  // ------------------------------------------------
  // Failure flag and watchdog tolerance
  // ------------------------------------------------
  reg  wd_seen_ff;
  wire wd_counts = wd_fail_event && (!wd_tolerant_cfg || wd_seen_ff);
  wire fail_set  = fail_cond || wd_counts;

  // Watchdog failure count and failure flag
  always @(posedge mclk)
  begin
    if (rst)
    begin
      wd_seen_ff        <= 1'b0;
      device_status_reg <= 1'b0;
    end
    else
    begin
      if (wd_fail_event)
        wd_seen_ff <= 1'b1;
      else if (failure_clear && !fail_cond)
        wd_seen_ff <= 1'b0;
      if (fail_set)
        device_status_reg <= 1'b1;
      else if (failure_clear)
        device_status_reg <= 1'b0;
    end
  end

  // Flag persists through Restart into Normal until cleared
  wire fo_active = device_status_reg || fail_force_on;

  // ------------------------------------------------
  // Pattern counters
  // ------------------------------------------------
  reg  [23:0] blink_cnt_ff;
  reg         blink_ph_ff;
  reg  [17:0] pwm_cnt_ff;
  reg  [17:0] pwm_high;

  // Duty threshold in cycles
  always @*
  begin
    case (fail_pwm_duty_sel)
      `FOGP_DUTY_10:  pwm_high = PWM_PERIOD[17:0] / 18'h0000A;
      `FOGP_DUTY_5:   pwm_high = PWM_PERIOD[17:0] / 18'h00014;
      `FOGP_DUTY_2P5: pwm_high = PWM_PERIOD[17:0] / 18'h00028;
      default:        pwm_high = PWM_PERIOD[17:0] / 18'h00005;
    endcase
  end

  // Counters run from restart while active, both from zero
  always @(posedge mclk)
  begin
    if (rst || !fo_active)
    begin
      blink_cnt_ff <= 24'h000000;
      blink_ph_ff  <= 1'b1;
      pwm_cnt_ff   <= 18'h00000;
    end
    else
    begin
      if (blink_cnt_ff == BLINK_HALF[23:0] - 24'h000001)
      begin
        blink_cnt_ff <= 24'h000000;
        blink_ph_ff  <= ~blink_ph_ff;
      end
      else
        blink_cnt_ff <= blink_cnt_ff + 24'h000001;
      if (pwm_cnt_ff == PWM_PERIOD[17:0] - 18'h00001)
        pwm_cnt_ff <= 18'h00000;
      else
        pwm_cnt_ff <= pwm_cnt_ff + 18'h00001;
    end
  end

  wire blink_on = fo_active && blink_ph_ff;
  wire pwm_on   = fo_active && (pwm_cnt_ff < pwm_high);

  // ------------------------------------------------
  // Pin level input path
  // ------------------------------------------------
  wire lvl_two;
  wire lvl_three;

  // Pin two level, synchronised
  fogp_sync_filt #(.FLT_CYC(1), .CW(12)) u_sync_two
  (
    .mclk     (mclk),
    .rst      (rst),
    .pin_in   (alt_pin_two_in),
    .level_ff (lvl_two)
  );

  // Pin three / test level, 64 us filter
  fogp_sync_filt #(.FLT_CYC(TEST_FLT), .CW(12)) u_sync_three
  (
    .mclk     (mclk),
    .rst      (rst),
    .pin_in   (test_pin_in),
    .level_ff (lvl_three)
  );

  // ------------------------------------------------
  // Wake detection
  // ------------------------------------------------
  wire wake_mode = !m_fsafe;
  fogp_wake_det u_wake_two
  (
    .mclk    (mclk),
    .rst     (rst),
    .enable  (wake_mode && cfg_two_ff == `FOGP_CFG_WAKE),
    .level   (lvl_two),
    .clear   (wake_clear),
    .wake_ff (wake_status_two[0])
  );
  fogp_wake_det u_wake_three
  (
    .mclk    (mclk),
    .rst     (rst),
    .enable  (wake_mode && cfg_three_ff == `FOGP_CFG_WAKE),
    .level   (lvl_three),
    .clear   (wake_clear),
    .wake_ff (wake_status_two[1])
  );

  // ------------------------------------------------
  // Level status, live in Normal and Stop
  // ------------------------------------------------
  assign test_level = pin_level_status[0];
  always @(posedge mclk)
  begin
    if (rst)
      pin_level_status <= 2'h3;
    else if (m_normal || m_stop)
    begin
      // Bit 0 doubles as test level when pin two is not GPIO
      pin_level_status[0] <= (cfg_two_ff == `FOGP_CFG_FO) ? lvl_three : lvl_two;
      pin_level_status[1] <= lvl_three;
    end
  end

  // ------------------------------------------------
  // Output drive
  // ------------------------------------------------
  wire sw_ok = !(m_restart || m_fsafe);
  always @(posedge mclk)
  begin
    if (rst)
    begin
      static_fail_out <= 1'b0;
      static_fail_oe  <= 1'b0;
      blink_fail_out  <= 1'b0;
      blink_fail_oe   <= 1'b0;
      blink_hs_on     <= 1'b0;
      dimmed_fail_out <= 1'b0;
      dimmed_fail_oe  <= 1'b0;
      dimmed_hs_on    <= 1'b0;
    end
    else
    begin
      static_fail_out <= 1'b0;
      static_fail_oe  <= fo_active;
      blink_fail_out  <= 1'b0;
      dimmed_fail_out <= 1'b0;
      case (cfg_two_ff)
        `FOGP_CFG_FO:
        begin
          blink_fail_oe <= blink_on;
          blink_hs_on   <= 1'b0;
        end
        `FOGP_CFG_LS:
        begin
          blink_fail_oe <= sw_ok && fail_force_on;
          blink_hs_on   <= 1'b0;
        end
        `FOGP_CFG_HS:
        begin
          blink_fail_oe <= 1'b0;
          blink_hs_on   <= sw_ok && fail_force_on;
        end
        default:
        begin
          blink_fail_oe <= 1'b0;
          blink_hs_on   <= 1'b0;
        end
      endcase
      case (cfg_three_ff)
        `FOGP_CFG_FO:
        begin
          dimmed_fail_oe <= pwm_on;
          dimmed_hs_on   <= 1'b0;
        end
        `FOGP_CFG_LS:
        begin
          dimmed_fail_oe <= sw_ok && fail_force_on;
          dimmed_hs_on   <= 1'b0;
        end
        `FOGP_CFG_HS:
        begin
          dimmed_fail_oe <= 1'b0;
          dimmed_hs_on   <= sw_ok && fail_force_on;
        end
        default:
        begin
          dimmed_fail_oe <= 1'b0;
          dimmed_hs_on   <= 1'b0;
        end
      endcase
    end
  end
endmodule // fogp_fail_out

//--- hw/fogp_defines.vh
// Constants for the fail output and alternate pin block
`ifndef FOGP_DEFINES_VH
`define FOGP_DEFINES_VH
// Clock rate
`define FOGP_CLK_HZ          20000000
// Blink: 1.25 Hz, half period = 0.4 s
`define FOGP_BLINK_MHZ       1250
`define FOGP_BLINK_HALF      (`FOGP_CLK_HZ / (`FOGP_BLINK_MHZ * 2) * 1000)
// PWM: 100 Hz
`define FOGP_PWM_HZ          100
`define FOGP_PWM_PERIOD      (`FOGP_CLK_HZ / `FOGP_PWM_HZ)
// Test pin filter 64 us
`define FOGP_TEST_FLT_US     64
`define FOGP_TEST_FLT_CYC    (`FOGP_TEST_FLT_US * (`FOGP_CLK_HZ / 1000000))
// Duty select codes
`define FOGP_DUTY_20         2'h0
`define FOGP_DUTY_10         2'h1
`define FOGP_DUTY_5          2'h2
`define FOGP_DUTY_2P5        2'h3
// Pin configuration codes
`define FOGP_CFG_FO          3'h0
`define FOGP_CFG_OFF         3'h1
`define FOGP_CFG_WAKE        3'h2
`define FOGP_CFG_LS          3'h3
`define FOGP_CFG_HS          3'h4
// System mode one-hot codes
`define FOGP_MODE_NORMAL     5'h01
`define FOGP_MODE_STOP       5'h02
`define FOGP_MODE_SLEEP      5'h04
`define FOGP_MODE_RESTART    5'h08
`define FOGP_MODE_FAILSAFE   5'h10
`endif

//--- hw/fogp_sync_filt.v
// Two-flop synchroniser with a stable-time filter
`timescale 1ns/10ps
module fogp_sync_filt
#(
  parameter FLT_CYC = 1280,
  parameter CW      = 12
)
(
  // Clock and reset
  input  wire          mclk,
  input  wire          rst,
  // Pin and filtered level
  input  wire          pin_in,
  output reg           level_ff
);
  reg          sync1_ff;
  reg          sync2_ff;
  reg [CW-1:0] cnt_ff;

  // --------------------------------------------------
  // Synchronise then filter
  // --------------------------------------------------
  always @(posedge mclk)
  begin
    if (rst)
    begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
      cnt_ff   <= {CW{1'b0}};
      level_ff <= 1'b1;
    end
    else
    begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
      if (sync2_ff == level_ff)
        cnt_ff <= {CW{1'b0}};
      else if (cnt_ff == FLT_CYC[CW-1:0] - 1'b1)
      begin
        level_ff <= sync2_ff; // Stable long enough
        cnt_ff   <= {CW{1'b0}};
      end
      else
        cnt_ff <= cnt_ff + 1'b1;
    end
  end
endmodule // fogp_sync_filt

//--- hw/fogp_wake_det.v
// Wake edge detector with latched status
`timescale 1ns/10ps
module fogp_wake_det
(
  // Clock and reset
  input  wire mclk,
  input  wire rst,
  // Control
  input  wire enable,
  input  wire level,
  input  wire clear,
  // Status
  output reg  wake_ff
);
  reg last_ff;

  // --------------------------------------------------
  // Any level change while enabled is a wake event
  // --------------------------------------------------
  always @(posedge mclk)
  begin
    if (rst)
    begin
      last_ff <= 1'b1;
      wake_ff <= 1'b0;
    end
    else
    begin
      last_ff <= level;
      if (enable && (level != last_ff))
        wake_ff <= 1'b1; // Set wins over clear
      else if (clear)
        wake_ff <= 1'b0;
    end
  end
endmodule // fogp_wake_det

//--- dv/fogp_properties.sv
// Concurrent checks on the fail output block ports
`timescale 1ns/10ps
`include "fogp_defines.vh"
module fogp_properties
(
  // Clock and reset
  input wire       mclk,
  input wire       rst,
  // Controls
  input wire [4:0] sys_mode,
  input wire       fail_cond,
  input wire       fail_force_on,
  input wire       failure_clear,
  input wire       cfg_wr,
  // Drives and status
  input wire       static_fail_oe,
  input wire       blink_fail_oe,
  input wire       blink_hs_on,
  input wire       dimmed_fail_oe,
  input wire       dimmed_hs_on,
  input wire       device_status_reg,
  input wire [2:0] cfg_two_rd,
  input wire [2:0] cfg_three_rd
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // Sequences
  // ------------------------------------------------------------
  sequence s_cut;
    (sys_mode[3] || sys_mode[4]) [*2];
  endsequence
  sequence s_hs_cmd;
    (fail_force_on && sys_mode == `FOGP_MODE_NORMAL && cfg_two_rd == `FOGP_CFG_HS) [*2];
  endsequence
  sequence s_ls_cmd;
    (fail_force_on && sys_mode == `FOGP_MODE_NORMAL && cfg_three_rd == `FOGP_CFG_LS) [*2];
  endsequence
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_flag_set;
    fail_cond |=> device_status_reg;
  endproperty
  property p_flag_hold;
    device_status_reg && !failure_clear |=> device_status_reg;
  endproperty
  property p_static_on;
    device_status_reg |=> static_fail_oe;
  endproperty
  property p_together;
    $rose(static_fail_oe) && cfg_two_rd == `FOGP_CFG_FO && cfg_three_rd == `FOGP_CFG_FO
      |-> blink_fail_oe && dimmed_fail_oe;
  endproperty
  property p_cfg_lock;
    cfg_wr && sys_mode != `FOGP_MODE_NORMAL |=> $stable(cfg_two_rd) && $stable(cfg_three_rd);
  endproperty
  property p_cut;
    s_cut |-> !blink_hs_on && !dimmed_hs_on && !(cfg_three_rd == `FOGP_CFG_LS && dimmed_fail_oe);
  endproperty
  property p_hs_on;
    s_hs_cmd |-> blink_hs_on && !blink_fail_oe;
  endproperty
  property p_ls_on;
    s_ls_cmd |-> dimmed_fail_oe && !dimmed_hs_on;
  endproperty
  property p_off_pin;
    (cfg_two_rd == `FOGP_CFG_OFF) [*2] |-> !blink_fail_oe && !blink_hs_on;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
  a_static_on: assert property (p_static_on) else $error("static pin idle");
  a_together: assert property (p_together) else $error("pins not together");
  a_cfg_lock: assert property (p_cfg_lock) else $error("config changed");
  a_cut: assert property (p_cut) else $error("switch not cut");
  a_hs_on: assert property (p_hs_on) else $error("high side idle");
  a_ls_on: assert property (p_ls_on) else $error("low side idle");
  a_off_pin: assert property (p_off_pin) else $error("off pin driven");
endmodule // fogp_properties

bind fogp_fail_out fogp_properties u_props
(
  .mclk(mclk), .rst(rst), .sys_mode(sys_mode), .fail_cond(fail_cond),
  .fail_force_on(fail_force_on), .failure_clear(failure_clear), .cfg_wr(cfg_wr),
  .static_fail_oe(static_fail_oe), .blink_fail_oe(blink_fail_oe),
  .blink_hs_on(blink_hs_on), .dimmed_fail_oe(dimmed_fail_oe),
  .dimmed_hs_on(dimmed_hs_on), .device_status_reg(device_status_reg),
  .cfg_two_rd(cfg_two_rd), .cfg_three_rd(cfg_three_rd)
);

//--- dv/fogp_pin_model.sv
// Load and wake source on one alternate pin
`timescale 1ns/10ps
module fogp_pin_model
(
  // Drive from the block
  input  wire pull_low,
  input  wire hs_on,
  // Outside wake source
  input  wire src_en,
  input  wire src_lvl,
  // Pin level
  output wire pin
);
  // Block drive wins, then the source, else the pull-up holds high
  assign pin = pull_low ? 1'b0 : hs_on ? 1'b1 : src_en ? src_lvl : 1'b1;
endmodule // fogp_pin_model

//--- dv/test_fail_output_and_alt_gpio.sv
// Self-checking bench for the fail output block
`timescale 1ns/10ps
`include "fogp_defines.vh"
module test_fail_output_and_alt_gpio;
  localparam PW = 200;
  reg        mclk, rst, fail_cond, wd_fail_event, wd_tolerant_cfg, fail_force_on;
  reg        failure_clear, cfg_wr, wake_clear;
  reg  [4:0] sys_mode;
  reg  [1:0] fail_pwm_duty_sel, src_en, src_lvl;
  reg  [2:0] cfg_two_wr, cfg_three_wr;
  wire       pin_two, pin_three, static_fail_oe, blink_fail_oe, blink_hs_on;
  wire       dimmed_fail_oe, dimmed_hs_on, device_status_reg, test_level;
  wire [1:0] wake_status_two, pin_level_status;
  wire [2:0] cfg_two_rd, cfg_three_rd;
  wire [2:0] oes = {dimmed_fail_oe, blink_fail_oe, static_fail_oe};
  int        error_cnt, comparisons, n;
  // ------------------------------------------------------------
  // Design and pin loads
  // ------------------------------------------------------------
  fogp_fail_out #(.BLINK_HALF(40), .PWM_PERIOD(PW), .TEST_FLT(8)) dut
  (
    .mclk(mclk), .rst(rst), .sys_mode(sys_mode), .fail_cond(fail_cond),
    .wd_fail_event(wd_fail_event), .wd_tolerant_cfg(wd_tolerant_cfg),
    .fail_force_on(fail_force_on), .failure_clear(failure_clear),
    .fail_pwm_duty_sel(fail_pwm_duty_sel), .cfg_two_wr(cfg_two_wr),
    .cfg_three_wr(cfg_three_wr), .cfg_wr(cfg_wr), .wake_clear(wake_clear),
    .alt_pin_two_in(pin_two), .test_pin_in(pin_three), .static_fail_out(),
    .static_fail_oe(static_fail_oe), .blink_fail_out(), .blink_fail_oe(blink_fail_oe),
    .blink_hs_on(blink_hs_on), .dimmed_fail_out(), .dimmed_fail_oe(dimmed_fail_oe),
    .dimmed_hs_on(dimmed_hs_on), .device_status_reg(device_status_reg),
    .wake_status_two(wake_status_two), .pin_level_status(pin_level_status),
    .test_level(test_level), .cfg_two_rd(cfg_two_rd), .cfg_three_rd(cfg_three_rd)
  );
  fogp_pin_model u_two (.pull_low(blink_fail_oe), .hs_on(blink_hs_on),
    .src_en(src_en[0]), .src_lvl(src_lvl[0]), .pin(pin_two));
  fogp_pin_model u_three (.pull_low(dimmed_fail_oe), .hs_on(dimmed_hs_on),
    .src_en(src_en[1]), .src_lvl(src_lvl[1]), .pin(pin_three));
  // Clock
  always #25 mclk = ~mclk;
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task step(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s exp %0h got %0h", nm, exp, got);
    end
  endtask
  // Length of the next full active run of one fail pin
  task hi_len(input int w);
    n = 0;
    while (oes[w] !== 1'b0 && n < 500)
    begin
      step(1);
      n++;
    end
    while (oes[w] !== 1'b1 && n < 500)
    begin
      step(1);
      n++;
    end
    n = 0;
    while (oes[w] === 1'b1 && n < 500)
    begin
      step(1);
      n++;
    end
  endtask
  task write_cfg(input logic [2:0] two, input logic [2:0] three);
    cfg_two_wr = two;
    cfg_three_wr = three;
    cfg_wr = 1'b1;
    step(1);
    cfg_wr = 1'b0;
    step(2);
  endtask
  task close_out;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog against a hang
  initial
  begin
    #(50 * 40000);
    error_cnt++;
    close_out;
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {mclk, fail_cond, wd_fail_event, wd_tolerant_cfg, fail_force_on} = 5'h00;
    {failure_clear, cfg_wr, wake_clear, fail_pwm_duty_sel, src_en} = 7'h00;
    {rst, src_lvl, sys_mode} = {3'h7, `FOGP_MODE_NORMAL};
    {cfg_two_wr, cfg_three_wr} = {`FOGP_CFG_FO, `FOGP_CFG_FO};
    step(12);
    rst = 1'b0;
    chk("cfg", {`FOGP_CFG_FO, `FOGP_CFG_FO}, {cfg_two_rd, cfg_three_rd});
    chk("oe", 3'h0, oes);
    chk("lvl", 2'h3, pin_level_status);
    fail_cond = 1'b1;
    step(1);
    fail_cond = 1'b0;
    chk("flag", 1'h1, device_status_reg);
    step(1);
    chk("oe", 3'h7, oes);
    hi_len(1);
    chk("blink", 16'h0028, n[15:0]);
    for (int s = 0; s < 4; s++)
    begin
      fail_pwm_duty_sel = s[1:0];
      hi_len(2);
      hi_len(2);
      chk("pwm", PW / (5 << s), n[15:0]);
    end
    chk("static", 1'h1, static_fail_oe);
    sys_mode = `FOGP_MODE_RESTART;
    step(5);
    sys_mode = `FOGP_MODE_NORMAL;
    step(2);
    chk("hold", 2'h3, {device_status_reg, static_fail_oe});
    // Clear while a cause is present loses, then wins once it is gone
    fail_cond = 1'b1;
    failure_clear = 1'b1;
    step(1);
    chk("setwin", 1'h1, device_status_reg);
    fail_cond = 1'b0;
    step(1);
    failure_clear = 1'b0;
    step(3);
    chk("clr", 4'h0, {device_status_reg, oes});
    fail_force_on = 1'b1;
    step(3);
    chk("force", 1'h1, static_fail_oe);
    fail_force_on = 1'b0;
    step(3);
    chk("unforce", 3'h0, oes);
    wd_tolerant_cfg = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      wd_fail_event = 1'b1;
      step(1);
      wd_fail_event = 1'b0;
      step(3);
      chk("wd", k, device_status_reg);
    end
    failure_clear = 1'b1;
    step(1);
    failure_clear = 1'b0;
    write_cfg(`FOGP_CFG_HS, `FOGP_CFG_LS);
    chk("cfg", {`FOGP_CFG_HS, `FOGP_CFG_LS}, {cfg_two_rd, cfg_three_rd});
    fail_force_on = 1'b1;
    step(1400);
    chk("sw", 2'h3, {blink_hs_on, dimmed_fail_oe});
    chk("lvl", 2'h1, pin_level_status);
    chk("tst", 1'h1, test_level);
    sys_mode = `FOGP_MODE_STOP;
    write_cfg(`FOGP_CFG_OFF, `FOGP_CFG_OFF);
    chk("lock", `FOGP_CFG_HS, cfg_two_rd);
    sys_mode = `FOGP_MODE_RESTART;
    step(3);
    chk("cut", 2'h0, {blink_hs_on, dimmed_fail_oe});
    sys_mode = `FOGP_MODE_NORMAL;
    step(3);
    chk("resume", 2'h3, {blink_hs_on, dimmed_fail_oe});
    // Swapped switch kinds, then both pins off
    write_cfg(`FOGP_CFG_LS, `FOGP_CFG_HS);
    chk("swap", 2'h3, {blink_fail_oe, dimmed_hs_on});
    write_cfg(`FOGP_CFG_OFF, `FOGP_CFG_OFF);
    chk("off", 4'h0, {blink_fail_oe, blink_hs_on, dimmed_fail_oe, dimmed_hs_on});
    fail_force_on = 1'b0;
    src_en = 2'h3;
    write_cfg(`FOGP_CFG_WAKE, `FOGP_CFG_WAKE);
    step(1400);
    wake_clear = 1'b1;
    step(1);
    wake_clear = 1'b0;
    src_lvl[1] = 1'b0;
    step(3);
    src_lvl[1] = 1'b1;
    step(40);
    chk("glitch", 2'h0, wake_status_two);
    src_lvl[1] = 1'b0;
    step(40);
    chk("wake", 2'h2, wake_status_two);
    chk("lvl", 2'h1, pin_level_status);
    wake_clear = 1'b1;
    step(1);
    wake_clear = 1'b0;
    sys_mode = `FOGP_MODE_SLEEP;
    src_lvl[0] = 1'b0;
    step(1400);
    chk("sleep", 2'h1, wake_status_two);
    wake_clear = 1'b1;
    step(1);
    wake_clear = 1'b0;
    sys_mode = `FOGP_MODE_FAILSAFE;
    src_lvl[0] = 1'b1;
    step(1400);
    chk("fsafe", 2'h0, wake_status_two);
    close_out;
  end
endmodule // test_fail_output_and_alt_gpio
